// file: hw/pps_defs.svh
//
// Behaviour
// - Class D amplifier in use: ignore gain command, apply fixed +0.0dB gain.
// - Two-byte play: accept second byte after first-byte processing time.
// - After final byte and final-byte processing time, read phrase from flash, then play.
// - Channel busy low from acceptance through processing plus phrase, high at end.
// - Next-command-ready low while preparing, high when sound output begins.
// - Next play for a channel accepted only while its next-command-ready is high.
// - Single-byte start behaves like two-byte play: flash read, busy, ready.
// - Stop with fade on a non-idle channel holds busy low for the fade time of the rate group.
// - Silence: after second byte and processing time, compute and play silence.
// - Silence busy low for processing time plus silence duration.
// - Silence queued during a phrase: ready low until phrase ends, then high.
// - Phrase queued during silence: ready low until silence ends and phrase starts.
// - Busy stays low through a whole chained sequence of phrases and silences.
// - Repeat-set only works during phrase playback; the phrase then repeats.
// - Ready held low while repeat mode is active.
// - Three-byte play: each further byte after first-byte processing time.
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

// Clock and processing times
`define PPS_CLK_MHZ         100
`define PPS_CLK_PER_NS      10
`define PPS_T_CB1_NS        2000
`define PPS_T_CB2_NS        5000
`define PPS_T_CB1_CYC       ((`PPS_T_CB1_NS + `PPS_CLK_PER_NS - 1) / `PPS_CLK_PER_NS)
`define PPS_T_CB2_CYC       ((`PPS_T_CB2_NS + `PPS_CLK_PER_NS - 1) / `PPS_CLK_PER_NS)
`define PPS_MS_US           1000
// Fade times per rate group, in units of 100 us
`define PPS_FADE_G0_100US   30
`define PPS_FADE_G1_100US   50
`define PPS_FADE_G2_100US   40
`define PPS_FADE_G3_100US   29
`define PPS_FADE_G4_100US   27

// First byte layout
`define PPS_OP_MSB          7
`define PPS_OP_LSB          4
`define PPS_FADE_BIT        3
`define PPS_CH_MSB          1
`define PPS_CH_LSB          0

// Gain code for +0.0dB and reset gain
`define PPS_GAIN_0DB        4'h0
`define PPS_GAIN_RST        4'h0

`endif

// file: hw/pps_pkg.sv
package pps_pkg;

  // Command opcodes in the first byte
  typedef enum logic [3:0] {
    PPS_OP_PLAY   = 4'h1,
    PPS_OP_PLAY3  = 4'h2,
    PPS_OP_START  = 4'h3,
    PPS_OP_SIL    = 4'h4,
    PPS_OP_STOP   = 4'h5,
    PPS_OP_RPTSET = 4'h6,
    PPS_OP_RPTCLR = 4'h7,
    PPS_OP_GAIN   = 4'h8
  } pps_op_e;

  // Item handed to a channel
  typedef struct packed {
    logic        sil;
    logic [23:0] len;
  } pps_item_s;

  // Control pulses to a channel
  typedef struct packed {
    logic prep;
    logic disp;
    logic stop;
    logic fade;
    logic rpt_set;
    logic rpt_clr;
  } pps_ctl_s;

endpackage

// file: hw/pps_chan.sv
`timescale 1ns/1ps
`include "pps_defs.svh"

module pps_chan
  import pps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire pps_ctl_s    ctl,
  input  wire pps_item_s   item,
  input  wire logic        sample_tick,
  input  wire logic        ms_tick,
  input  wire logic [23:0] fade_cyc,
  output logic             channel_busy_n,
  output logic             next_cmd_ready,
  output logic             playing
);

  typedef enum logic [1:0] {PPS_CH_IDLE, PPS_CH_RUN, PPS_CH_FADE} pps_ch_e;

  pps_ch_e     st_ff;
  logic        prep_ff;
  logic        pend_ff;
  pps_item_s   pend_item_ff;
  pps_item_s   cur_ff;
  logic [23:0] cnt_ff;
  logic        rpt_ff;
  logic        tick;
  logic        done;

  assign tick = cur_ff.sil ? ms_tick : sample_tick;
  assign done = (st_ff == PPS_CH_RUN) && tick && (cnt_ff <= 24'h00_0001);

  // Sequencing of current item, queue, repeat and fade
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff        <= PPS_CH_IDLE;
      pend_ff      <= 1'b0;
      pend_item_ff <= '0;
      cur_ff       <= '0;
      cnt_ff       <= 24'h00_0000;
    end else if (ctl.stop) begin
      pend_ff <= 1'b0;
      if (ctl.fade && st_ff != PPS_CH_IDLE) begin
        st_ff  <= PPS_CH_FADE;
        cnt_ff <= fade_cyc;
      end else begin
        st_ff <= PPS_CH_IDLE;
      end
    end else begin
      unique case (st_ff)
        PPS_CH_IDLE: begin
          if (ctl.disp) begin
            st_ff  <= PPS_CH_RUN;
            cur_ff <= item;
            cnt_ff <= item.len;
          end
        end
        PPS_CH_RUN: begin
          if (ctl.disp) begin
            pend_ff      <= 1'b1;
            pend_item_ff <= item;
          end
          if (done) begin
            if (rpt_ff && !cur_ff.sil) begin
              cnt_ff <= cur_ff.len;
            end else if (pend_ff) begin
              pend_ff <= 1'b0;
              cur_ff  <= pend_item_ff;
              cnt_ff  <= pend_item_ff.len;
            end else if (ctl.disp) begin
              pend_ff <= 1'b0;
              cur_ff  <= item;
              cnt_ff  <= item.len;
            end else begin
              st_ff <= PPS_CH_IDLE;
            end
          end else if (tick) begin
            cnt_ff <= cnt_ff - 24'h00_0001;
          end
        end
        PPS_CH_FADE: begin
          if (cnt_ff <= 24'h00_0001) begin
            st_ff <= PPS_CH_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 24'h00_0001;
          end
        end
      endcase
    end
  end

  // Preparation flag from acceptance to hand-over
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prep_ff <= 1'b0;
    end else if (ctl.stop || ctl.disp) begin
      prep_ff <= 1'b0;
    end else if (ctl.prep) begin
      prep_ff <= 1'b1;
    end
  end

  // Repeat mode, only for a playing phrase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rpt_ff <= 1'b0;
    end else if (ctl.stop || ctl.rpt_clr || st_ff == PPS_CH_IDLE) begin
      rpt_ff <= 1'b0;
    end else if (ctl.rpt_set && st_ff == PPS_CH_RUN && !cur_ff.sil) begin
      rpt_ff <= 1'b1;
    end
  end

  // Handshake outputs
  assign channel_busy_n = !(prep_ff || st_ff != PPS_CH_IDLE);
  assign next_cmd_ready = !(prep_ff || pend_ff || rpt_ff);
  assign playing        = (st_ff == PPS_CH_RUN);

endmodule

// file: hw/pps_top.sv
`timescale 1ns/1ps
`include "pps_defs.svh"

module pps_top
  import pps_pkg::*;
#(
  parameter int NCH          = 4,
  parameter int MS_CYC       = `PPS_MS_US * `PPS_CLK_MHZ,
  parameter int FADE_G0_CYC  = `PPS_FADE_G0_100US * 100 * `PPS_CLK_MHZ,
  parameter int FADE_G1_CYC  = `PPS_FADE_G1_100US * 100 * `PPS_CLK_MHZ,
  parameter int FADE_G2_CYC  = `PPS_FADE_G2_100US * 100 * `PPS_CLK_MHZ,
  parameter int FADE_G3_CYC  = `PPS_FADE_G3_100US * 100 * `PPS_CLK_MHZ,
  parameter int FADE_G4_CYC  = `PPS_FADE_G4_100US * 100 * `PPS_CLK_MHZ
)
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            cmd_valid,
  input  wire logic [7:0]      cmd_byte,
  output logic                 cmd_busy_n,
  output logic                 flash_req,
  output logic [11:0]          flash_addr,
  input  wire logic            flash_ack,
  input  wire logic [23:0]     flash_rdata,
  input  wire logic [NCH-1:0]  sample_tick,
  input  wire logic [2:0]      fade_grp,
  input  wire logic            class_d_sel,
  output logic [3:0]           amp_gain,
  output logic [NCH-1:0]       channel_busy_n,
  output logic [NCH-1:0]       next_cmd_ready,
  output logic [NCH-1:0]       playing
);

  localparam int CB1_CYC = `PPS_T_CB1_CYC;
  localparam int CB2_CYC = `PPS_T_CB2_CYC;

  typedef enum logic [2:0] {
    PPS_FE_B1, PPS_FE_T1, PPS_FE_B2, PPS_FE_B3, PPS_FE_T2, PPS_FE_FLASH, PPS_FE_WAIT
  } pps_fe_e;

  pps_fe_e           fe_ff;
  pps_fe_e           ret_ff;
  logic [3:0]        op_ff;
  logic              fade_ff;
  logic [1:0]        ch_ff;
  logic [11:0]       phrase_ff;
  logic [7:0]        sil_ff;
  logic [15:0]       wait_ff;
  logic [11:0]       last_phrase_ff [NCH];
  logic [3:0]        gain_ff;
  logic [16:0]       ms_cnt_ff;
  logic              ms_tick_ff;
  logic [2:0]        cls_sync_ff;
  logic              cls_d_ff;
  pps_item_s         item_ff;
  pps_ctl_s          ctl_ff [NCH];
  logic [23:0]       fade_cyc;
  logic              take;
  logic              is_play_op;
  logic              last_byte;

  // Whole-number op decode used at several points
  function automatic logic needs_play(input logic [3:0] op);
    needs_play = (op == PPS_OP_PLAY) || (op == PPS_OP_PLAY3) || (op == PPS_OP_START)
                 || (op == PPS_OP_SIL);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Byte acceptance

  // Bytes taken only while the interpreter waits for one
  assign cmd_busy_n = (fe_ff == PPS_FE_B1) || (fe_ff == PPS_FE_B2) || (fe_ff == PPS_FE_B3);
  assign take       = cmd_valid && cmd_busy_n;
  assign is_play_op = needs_play(op_ff);
  assign last_byte  = take && ((fe_ff == PPS_FE_B3) || (fe_ff == PPS_FE_B2 && op_ff != PPS_OP_PLAY3));

  // Interpreter sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fe_ff     <= PPS_FE_B1;
      ret_ff    <= PPS_FE_B1;
      op_ff     <= 4'h0;
      fade_ff   <= 1'b0;
      ch_ff     <= 2'h0;
      phrase_ff <= 12'h000;
      sil_ff    <= 8'h00;
      wait_ff   <= 16'h0000;
    end else begin
      unique case (fe_ff)
        PPS_FE_B1: begin
          if (take) begin
            op_ff   <= cmd_byte[`PPS_OP_MSB:`PPS_OP_LSB];
            fade_ff <= cmd_byte[`PPS_FADE_BIT];
            ch_ff   <= cmd_byte[`PPS_CH_MSB:`PPS_CH_LSB];
            wait_ff <= 16'(CB1_CYC);
            fe_ff   <= PPS_FE_T1;
            ret_ff  <= PPS_FE_B1;
            unique case (cmd_byte[`PPS_OP_MSB:`PPS_OP_LSB])
              PPS_OP_PLAY, PPS_OP_PLAY3, PPS_OP_SIL, PPS_OP_GAIN: begin
                ret_ff <= PPS_FE_B2;
              end
              PPS_OP_START: begin
                phrase_ff <= last_phrase_ff[cmd_byte[`PPS_CH_MSB:`PPS_CH_LSB]];
                if (next_cmd_ready[cmd_byte[`PPS_CH_MSB:`PPS_CH_LSB]]) begin
                  wait_ff <= 16'(CB2_CYC);
                  fe_ff   <= PPS_FE_T2;
                end
              end
              default: begin
              end
            endcase
          end
        end
        PPS_FE_T1, PPS_FE_T2: begin
          if (wait_ff <= 16'h0001) begin
            if (fe_ff == PPS_FE_T1) begin
              fe_ff <= ret_ff;
            end else if (op_ff == PPS_OP_SIL) begin
              fe_ff <= PPS_FE_WAIT;
            end else begin
              fe_ff <= PPS_FE_FLASH;
            end
          end else begin
            wait_ff <= wait_ff - 16'h0001;
          end
        end
        PPS_FE_B2: begin
          if (take) begin
            if (op_ff == PPS_OP_PLAY3) begin
              phrase_ff[11:8] <= cmd_byte[3:0];
              wait_ff         <= 16'(CB1_CYC);
              fe_ff           <= PPS_FE_T1;
              ret_ff          <= PPS_FE_B3;
            end else begin
              phrase_ff <= {4'h0, cmd_byte};
              sil_ff    <= cmd_byte;
            end
          end
        end
        PPS_FE_B3: begin
          if (take) begin
            phrase_ff[7:0] <= cmd_byte;
          end
        end
        PPS_FE_FLASH: begin
          if (flash_ack) begin
            fe_ff <= PPS_FE_WAIT;
          end
        end
        PPS_FE_WAIT: begin
          fe_ff <= PPS_FE_B1;
        end
      endcase
      // Final byte: play-type needs a free channel, others just settle
      if (last_byte) begin
        if (is_play_op && next_cmd_ready[ch_ff]) begin
          wait_ff <= 16'(CB2_CYC);
          fe_ff   <= PPS_FE_T2;
        end else begin
          wait_ff <= 16'(CB1_CYC);
          fe_ff   <= PPS_FE_T1;
          ret_ff  <= PPS_FE_B1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flash fetch and item build

  assign flash_req  = (fe_ff == PPS_FE_FLASH);
  assign flash_addr = phrase_ff;

  // Item latched from flash or silence length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      item_ff <= '0;
    end else if (fe_ff == PPS_FE_FLASH && flash_ack) begin
      item_ff <= '{sil: 1'b0, len: flash_rdata};
    end else if (fe_ff == PPS_FE_T2 && op_ff == PPS_OP_SIL) begin
      item_ff <= '{sil: 1'b1, len: {16'h0000, sil_ff}};
    end
  end

  // Phrase remembered per channel for the start command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        last_phrase_ff[i] <= 12'h000;
      end
    end else if (fe_ff == PPS_FE_FLASH && flash_ack) begin
      last_phrase_ff[ch_ff] <= phrase_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel control pulses

  // One-cycle pulses to the addressed channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        ctl_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ctl_ff[i] <= '0;
        if (ch_ff == 2'(i)) begin
          ctl_ff[i].prep <= last_byte && is_play_op && next_cmd_ready[i];
          ctl_ff[i].disp <= (fe_ff == PPS_FE_WAIT);
        end
        if (take && fe_ff == PPS_FE_B1 && cmd_byte[`PPS_CH_MSB:`PPS_CH_LSB] == 2'(i)) begin
          ctl_ff[i].stop    <= (cmd_byte[`PPS_OP_MSB:`PPS_OP_LSB] == PPS_OP_STOP);
          ctl_ff[i].fade    <= cmd_byte[`PPS_FADE_BIT];
          ctl_ff[i].rpt_set <= (cmd_byte[`PPS_OP_MSB:`PPS_OP_LSB] == PPS_OP_RPTSET);
          ctl_ff[i].rpt_clr <= (cmd_byte[`PPS_OP_MSB:`PPS_OP_LSB] == PPS_OP_RPTCLR);
        end
        // Start needs the free-channel check at its only byte
        if (take && fe_ff == PPS_FE_B1 && cmd_byte[`PPS_CH_MSB:`PPS_CH_LSB] == 2'(i)
            && cmd_byte[`PPS_OP_MSB:`PPS_OP_LSB] == PPS_OP_START && next_cmd_ready[i]) begin
          ctl_ff[i].prep <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond enable for silence timing

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_ff  <= 17'h0_0000;
      ms_tick_ff <= 1'b0;
    end else if (ms_cnt_ff >= 17'(MS_CYC - 1)) begin
      ms_cnt_ff  <= 17'h0_0000;
      ms_tick_ff <= 1'b1;
    end else begin
      ms_cnt_ff  <= ms_cnt_ff + 17'h0_0001;
      ms_tick_ff <= 1'b0;
    end
  end

  // Fade length by rate group
  always_comb begin
    unique case (fade_grp)
      3'h0:    fade_cyc = 24'(FADE_G0_CYC);
      3'h1:    fade_cyc = 24'(FADE_G1_CYC);
      3'h2:    fade_cyc = 24'(FADE_G2_CYC);
      3'h3:    fade_cyc = 24'(FADE_G3_CYC);
      default: fade_cyc = 24'(FADE_G4_CYC);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Amplifier gain

  // Amplifier class strap from the pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cls_sync_ff <= 3'h0;
      cls_d_ff    <= 1'b0;
    end else begin
      cls_sync_ff <= {cls_sync_ff[1:0], class_d_sel};
      if (cls_sync_ff[1] == cls_sync_ff[2]) begin
        cls_d_ff <= cls_sync_ff[2];
      end
    end
  end

  // Stored gain setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_ff  <= `PPS_GAIN_RST;
      amp_gain <= `PPS_GAIN_RST;
    end else begin
      if (take && fe_ff == PPS_FE_B2 && op_ff == PPS_OP_GAIN) begin
        gain_ff <= cmd_byte[3:0];
      end
      amp_gain <= cls_d_ff ? `PPS_GAIN_0DB : gain_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channels

  // Independent sequencer per channel
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    pps_chan u_chan (
      .clk            (clk),
      .rst_n          (rst_n),
      .ctl            (ctl_ff[g]),
      .item           (item_ff),
      .sample_tick    (sample_tick[g]),
      .ms_tick        (ms_tick_ff),
      .fade_cyc       (fade_cyc),
      .channel_busy_n (channel_busy_n[g]),
      .next_cmd_ready (next_cmd_ready[g]),
      .playing        (playing[g])
    );
  end

endmodule

// file: tb/pps_top_monitor.sv
`timescale 1ns/1ps
module pps_top_monitor
  import pps_pkg::*;
#(
  parameter int NCH = 4
)
(
  input wire logic           clk,
  input wire logic           rst_n,
  input wire logic           cmd_valid,
  input wire logic [7:0]     cmd_byte,
  input wire logic           cmd_busy_n,
  input wire logic           flash_req,
  input wire logic [11:0]    flash_addr,
  input wire logic           flash_ack,
  input wire logic [23:0]    flash_rdata,
  input wire logic [NCH-1:0] sample_tick,
  input wire logic [2:0]     fade_grp,
  input wire logic           class_d_sel,
  input wire logic [3:0]     amp_gain,
  input wire logic [NCH-1:0] channel_busy_n,
  input wire logic [NCH-1:0] next_cmd_ready,
  input wire logic [NCH-1:0] playing
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic [15:0] busy_cnt_ff;
  logic [15:0] nxt_busy_cnt;

  // Cycles the byte port has been busy in a row
  assign nxt_busy_cnt = cmd_busy_n ? 16'h0000 : busy_cnt_ff + 16'h0001;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_ff <= 16'h0000;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end

  ////////////////////////////////////////
  // Byte port and flash handshake
  take_busy_a: assert property (cmd_valid && cmd_busy_n |=> !cmd_busy_n)
    else $error("byte taken but port not busy");
  byte_gap_a: assert property ($rose(cmd_busy_n) |-> busy_cnt_ff >= 16'h00c7)
    else $error("port ready before byte time");
  fetch_delay_a: assert property ($rose(flash_req) |-> !cmd_busy_n && busy_cnt_ff >= 16'h01f3)
    else $error("flash read before final byte time");
  flash_hold_a: assert property (flash_req && !flash_ack |=> flash_req && $stable(flash_addr))
    else $error("flash request dropped early");
  start_after_ack_a: assert property (flash_ack |-> ##[1:4] (cmd_busy_n && |playing))
    else $error("playback not started after fetch");
  // Channel outputs and amplifier gain
  ready_low_busy_a: assert property ((~next_cmd_ready & channel_busy_n) == '0)
    else $error("ready low on an idle channel");
  play_busy_a: assert property ((playing & channel_busy_n) == '0)
    else $error("channel idle while playing");
  class_d_gain_a: assert property (class_d_sel [*5] |=> amp_gain == 4'h0)
    else $error("gain not fixed with class D");

  // Main scenarios reached
  cover property ($rose(flash_req));
  cover property (|(~next_cmd_ready & playing));
  cover property (amp_gain != 4'h0);
endmodule

bind pps_top pps_top_monitor #(.NCH(NCH)) u_pps_mon (.clk, .rst_n, .cmd_valid, .cmd_byte, .cmd_busy_n,
  .flash_req, .flash_addr, .flash_ack, .flash_rdata, .sample_tick, .fade_grp, .class_d_sel, .amp_gain,
  .channel_busy_n, .next_cmd_ready, .playing);

// file: tb/pps_flash_model.sv
`timescale 1ns/1ps
module pps_flash_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        flash_req,
  input  wire logic [11:0] flash_addr,
  input  wire logic        slow,
  output logic             flash_ack,
  output logic [23:0]      flash_rdata
);
  logic [4:0] wait_ff;

  // Answers a held request fast or slow; idle data toggles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_ack   <= 1'b0;
      flash_rdata <= 24'h00_0000;
      wait_ff     <= 5'h00;
    end else begin
      flash_ack   <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_req && !flash_ack) begin
        wait_ff <= wait_ff + 5'h01;
        if (wait_ff >= (slow ? 5'h0c : 5'h00)) begin
          flash_ack   <= 1'b1;
          flash_rdata <= {14'h0000, flash_addr[7:0], 2'b00} + 24'h00_0008;
          wait_ff     <= 5'h00;
        end
      end
    end
  end
endmodule

// file: tb/pps_top_tb.sv
`timescale 1ns/1ps
module pps_top_tb
  import pps_pkg::*;
;
  localparam int FADE_CYC [6] = '{30, 50, 40, 29, 27, 27};
  logic        clk = 1'b0;
  logic        rst_n, cmd_valid, class_d_sel, slow, cmd_busy_n, flash_req, flash_ack, req_d;
  logic [7:0]  cmd_byte;
  logic [3:0]  sample_tick = 4'h0;
  logic [3:0]  amp_gain, channel_busy_n, next_cmd_ready, playing;
  logic [2:0]  fade_grp;
  logic [11:0] flash_addr;
  logic [23:0] flash_rdata;
  logic [31:0] lfsr = 32'h0000_085f;
  logic [11:0] exp_q[$];
  int          num_errors, num_checks;

  pps_top #(.MS_CYC(20), .FADE_G0_CYC(FADE_CYC[0]), .FADE_G1_CYC(FADE_CYC[1]), .FADE_G2_CYC(FADE_CYC[2]),
    .FADE_G3_CYC(FADE_CYC[3]), .FADE_G4_CYC(FADE_CYC[4])) DUT (.clk, .rst_n, .cmd_valid, .cmd_byte,
    .cmd_busy_n, .flash_req, .flash_addr, .flash_ack, .flash_rdata, .sample_tick, .fade_grp, .class_d_sel,
    .amp_gain, .channel_busy_n, .next_cmd_ready, .playing);
  pps_flash_model u_flash (.clk, .rst_n, .flash_req, .flash_addr, .slow, .flash_ack, .flash_rdata);

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random sample ticks and flash pacing
  always @(posedge clk) begin
    lfsr        <= lfsr_next(lfsr);
    sample_tick <= lfsr[3:0];
    slow        <= lfsr[9];
  end

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Each new fetch takes the oldest noted phrase
  always @(negedge clk) begin
    req_d <= flash_req;
    if (rst_n && flash_req === 1'b1 && req_d !== 1'b1) begin
      if (exp_q.size() == 0) check("flash_req", 24'(flash_req), 24'h00_0000);
      else check("flash_addr", 24'(flash_addr), 24'(exp_q.pop_front()));
    end
  end

  // Bounded wait: 0 ready, 1 channel busy, 2 byte port
  task automatic wait_for(input int sel, input int ch, input logic lvl);
    int n;
    n = 0;
    @(negedge clk);
    while ((sel == 0 ? next_cmd_ready[ch] : sel == 1 ? channel_busy_n[ch] : cmd_busy_n) !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        check("wait_bound", 24'h00_0000, 24'h00_0001);
        give_verdict();
      end
    end
  endtask

  task automatic send_byte(input logic [7:0] b);
    wait_for(2, 0, 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_byte  <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_byte  <= ~b;
  endtask

  task automatic play(input logic [1:0] ch, input logic [7:0] ph, input bit kept);
    send_byte({PPS_OP_PLAY, 2'b00, ch});
    if (kept) exp_q.push_back({4'h0, ph});
    send_byte(ph);
  endtask

  task automatic count_low(input int ch, output int n);
    repeat (3) @(negedge clk);
    n = 3;
    while (channel_busy_n[ch] === 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        check("low_bound", 24'h00_0000, 24'h00_0001);
        give_verdict();
      end
    end
  endtask

  // Main sequence
  initial begin
    int          n;
    logic [11:0] ph;
    rst_n       = 1'b0;
    cmd_valid   = 1'b0;
    class_d_sel = 1'b0;
    cmd_byte    = 8'h00;
    fade_grp    = 3'h0;
    num_errors  = 0;
    num_checks  = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("rst_outs", {10'h000, next_cmd_ready, channel_busy_n, playing, cmd_busy_n, flash_req}, 24'h00_3fc2);
    send_byte({PPS_OP_GAIN, 4'h0});
    send_byte(8'h09);
    wait_for(2, 0, 1'b1);
    check("amp_gain_ab", 24'(amp_gain), 24'h00_0009);
    @(posedge clk);
    class_d_sel <= 1'b1;
    repeat (8) @(negedge clk);
    check("amp_gain_d", 24'(amp_gain), 24'h00_0000);
    @(posedge clk);
    class_d_sel <= 1'b0;
    send_byte(8'hf1);
    // Phrase, queued silence, refused play, queued phrase on channel 0
    play(2'd0, 8'hff, 1'b1);
    wait_for(2, 0, 1'b1);
    @(negedge clk);
    check("ch0_play", {20'h0_0000, playing[0], channel_busy_n[0], next_cmd_ready[1], channel_busy_n[1]}, 24'h00_000b);
    check("ch0_ready", 24'(next_cmd_ready[0]), 24'h00_0001);
    send_byte({PPS_OP_SIL, 4'h0});
    send_byte(8'h3c);
    wait_for(2, 0, 1'b1);
    @(negedge clk);
    check("ch0_sil_q", {22'h00_0000, next_cmd_ready[0], channel_busy_n[0]}, 24'h00_0000);
    play(2'd0, 8'h05, 1'b0);
    wait_for(0, 0, 1'b1);
    check("ch0_sil_go", {22'h00_0000, playing[0], channel_busy_n[0]}, 24'h00_0002);
    play(2'd0, lfsr[7:0], 1'b1);
    wait_for(2, 0, 1'b1);
    @(negedge clk);
    check("ch0_ph_q", {22'h00_0000, next_cmd_ready[0], channel_busy_n[0]}, 24'h00_0000);
    wait_for(0, 0, 1'b1);
    check("ch0_ph_go", {22'h00_0000, playing[0], channel_busy_n[0]}, 24'h00_0002);
    wait_for(1, 0, 1'b1);
    // Three-byte play, start replay, timed silence on channel 1
    ph = lfsr[11:0];
    send_byte({PPS_OP_PLAY3, 4'h1});
    send_byte({4'h0, ph[11:8]});
    exp_q.push_back(ph);
    send_byte(ph[7:0]);
    send_byte({PPS_OP_START, 4'h1});
    exp_q.push_back(ph);
    wait_for(2, 0, 1'b1);
    wait_for(0, 1, 1'b1);
    check("ch1_start", {23'h00_0000, playing[1]}, 24'h00_0001);
    wait_for(1, 1, 1'b1);
    send_byte({PPS_OP_SIL, 4'h1});
    send_byte(8'h03);
    count_low(1, n);
    check("sil_len", 24'(n >= 540 && n <= 580), 24'h00_0001);
    // Repeat set keeps channel 2 going past one pass
    play(2'd2, 8'hff, 1'b1);
    wait_for(2, 0, 1'b1);
    send_byte({PPS_OP_RPTSET, 4'h2});
    wait_for(2, 0, 1'b1);
    repeat (2500) @(negedge clk);
    check("rpt_hold", {22'h00_0000, next_cmd_ready[2], channel_busy_n[2]}, 24'h00_0000);
    send_byte({PPS_OP_RPTCLR, 4'h2});
    repeat (2) @(negedge clk);
    check("rpt_clr", 24'(next_cmd_ready[2]), 24'h00_0001);
    send_byte({PPS_OP_STOP, 4'h2});
    wait_for(2, 0, 1'b1);
    check("stop_idle", 24'(channel_busy_n[2]), 24'h00_0001);
    // Fade stop in every rate group, plus an out-of-range one
    for (int g = 0; g < 6; g++) begin
      @(posedge clk);
      fade_grp <= 3'(g);
      play(2'd3, 8'hff, 1'b1);
      wait_for(2, 0, 1'b1);
      send_byte({PPS_OP_STOP, 4'hb});
      count_low(3, n);
      check("fade_len", 24'(n >= FADE_CYC[g] && n <= FADE_CYC[g] + 5), 24'h00_0001);
    end
    check("flash_left", 24'(exp_q.size()), 24'h00_0000);
    give_verdict();
  end
endmodule
